/* File: rtl/fm_counter_regs.vh */
`ifndef FM_COUNTER_REGS_VH
`define FM_COUNTER_REGS_VH
// Feedback word offset and layout
`define FB_WORD_OFFSET      4'h0
`define CNT_WIDTH           25
`define CNT_MSB             24
`define CNT_ALL_ONES        25'h1FF_FFFF
`define CNT_ZERO            25'h000_0000
`define BIT_GATE            25
`define BIT_DIR             26
`define BIT_INPUT_LEVEL     27
`define BIT_GROUP_FAULT     28
`define BIT_CONFIG_FAULT    29
`define BIT_SYNC_APPLIED    30
`define BIT_HEARTBEAT       31
`define FB_RESET            32'h0000_0000
// Input function codes
`define FN_OFF              2'h0
`define FN_INPUT            2'h1
`define FN_GATE             2'h2
`define FN_SYNC             2'h3
`endif

/* File: rtl/edge_detect.v */
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_level,
  output wire o_rise,
  output wire o_fall
);
  reg last;

  // Previous level for edge compare
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last <= 1'b0;
    end else begin
      last <= i_level;
    end
  end

  assign o_rise = i_level & ~last;
  assign o_fall = ~i_level & last;
endmodule
`default_nettype wire

/* File: rtl/fast_mode_position_counter.v */
`timescale 1ns/1ps
`default_nettype none
`include "fm_counter_regs.vh"
// Behaviour
// - 25-bit unsigned count in low bits
// - Up from all ones wraps to zero
// - Down from zero wraps to all ones
// - Load value is start value
// - Parameter assignment sets count to load
// - Input function: off, input, gate, sync
// - Gate opens rising, closes falling edge
// - Without gate, count right after configuration
// - Reopened gate resumes from held count
// - Sync rising edge loads start value
// - Sync loads only while counting active
// - Input level bit shows input level
// - Heartbeat inverts every feedback update
// - Sync-applied bit when isochronous configured
// - Config fault set invalid, cleared valid
// - Group fault follows supply short circuit
// - Direction bit 1 toward smaller positions
// - Gate status bit equals counting active
// - Four feedback bytes captured as one
// - Report values at input sample instant
// - No control data accepted, input only
module fast_mode_position_counter (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_param_load,
  input  wire [24:0] i_param_load_value,
  input  wire [1:0]  i_param_input_fn,
  input  wire        i_param_invert,
  input  wire        i_param_valid,
  input  wire        i_param_isochronous,
  input  wire        i_count_pulse,
  input  wire        i_count_down,
  input  wire        i_aux_input,
  input  wire        i_supply_short,
  input  wire        i_input_sample_instant,
  input  wire        i_rd,
  input  wire [3:0]  i_addr,
  output reg  [31:0] o_rdata,
  output reg         o_word_valid
);
  // Configuration held from the last parameter assignment
  reg [24:0] load_value;
  reg [1:0]  input_fn;
  reg        configured;
  reg        config_fault;
  reg        sync_cycle_applied;
  // Counter state
  reg [24:0] count;
  reg        gate_open;
  reg        count_direction_status;
  reg        heartbeat_toggle;
  reg        pending_fault;
  reg [31:0] feedback_status_word;
  reg [24:0] next_count;

  wire aux_rise;
  wire aux_fall;
  wire counting_active;
  wire sync_hit;

  edge_detect u_aux_edge (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (i_aux_input),
    .o_rise  (aux_rise),
    .o_fall  (aux_fall)
  );

  // Gate only matters when the input is assigned as pin_gate
  assign counting_active = configured & ~config_fault &
                           ((input_fn != `FN_GATE) | gate_open);
  assign sync_hit = (input_fn == `FN_SYNC) & aux_rise & counting_active;

  // Parameter assignment; an inverted gate without gate function is invalid
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_value         <= `CNT_ZERO;
      input_fn           <= `FN_OFF;
      configured         <= 1'b0;
      config_fault       <= 1'b0;
      sync_cycle_applied <= 1'b0;
    end else if (i_param_load) begin
      load_value         <= i_param_load_value;
      input_fn           <= i_param_input_fn;
      configured         <= 1'b1;
      config_fault       <= ~i_param_valid |
                            (i_param_invert & (i_param_input_fn != `FN_GATE));
      sync_cycle_applied <= i_param_isochronous;
    end
  end

  // Gate follows input edges; opens rising, closes falling
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_open <= 1'b0;
    end else if (i_param_load) begin
      gate_open <= 1'b0;
    end else if (input_fn == `FN_GATE) begin
      if (aux_rise) begin
        gate_open <= 1'b1;
      end else if (aux_fall) begin
        gate_open <= 1'b0;
      end
    end
  end

  // Next count; 25-bit arithmetic wraps naturally with no lost pulse
  always @* begin
    next_count = count;
    if (i_param_load) begin
      next_count = i_param_load_value;
    end else if (sync_hit) begin
      next_count = load_value;
    end else if (counting_active & i_count_pulse) begin
      if (i_count_down) begin
        next_count = count - 25'h000_0001;
      end else begin
        next_count = count + 25'h000_0001;
      end
    end
  end

  // Count register; held while gate closed so reopening resumes
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count                  <= `CNT_ZERO;
      count_direction_status <= 1'b0;
    end else begin
      count <= next_count;
      if (counting_active & i_count_pulse & ~i_param_load & ~sync_hit) begin
        count_direction_status <= i_count_down;
      end
    end
  end

  // Fault latched between samples so a short pulse still shows once
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_fault <= 1'b0;
    end else if (i_input_sample_instant) begin
      pending_fault <= i_supply_short;
    end else if (i_supply_short) begin
      pending_fault <= 1'b1;
    end
  end

  // Snapshot whole word at sample instant; one register keeps bytes consistent
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      feedback_status_word <= `FB_RESET;
      heartbeat_toggle     <= 1'b0;
    end else if (i_input_sample_instant) begin
      heartbeat_toggle <= ~heartbeat_toggle;
      feedback_status_word[`CNT_MSB:0]        <= count;
      feedback_status_word[`BIT_GATE]         <= counting_active;
      feedback_status_word[`BIT_DIR]          <= count_direction_status;
      feedback_status_word[`BIT_INPUT_LEVEL]  <= i_aux_input;
      feedback_status_word[`BIT_GROUP_FAULT]  <= i_supply_short | pending_fault;
      feedback_status_word[`BIT_CONFIG_FAULT] <= config_fault;
      feedback_status_word[`BIT_SYNC_APPLIED] <= sync_cycle_applied & configured;
      feedback_status_word[`BIT_HEARTBEAT]    <= ~heartbeat_toggle;
    end
  end

  // Read port only; no write path exists
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata      <= `FB_RESET;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= i_rd;
      if (i_rd) begin
        o_rdata <= (i_addr == `FB_WORD_OFFSET) ? feedback_status_word : `FB_RESET;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/fmpc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fmpc_props (
  input wire logic        i_clk, i_rst, i_param_load, i_param_valid, i_supply_short,
  input wire logic        i_input_sample_instant, i_rd, o_word_valid,
  input wire logic [24:0] i_param_load_value,
  input wire logic [1:0]  i_param_input_fn,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_vld; i_rd |=> o_word_valid; endproperty
  a_vld: assert property (p_vld) else $error("no valid");
  property p_nvl; !i_rd |=> !o_word_valid; endproperty
  a_nvl: assert property (p_nvl) else $error("stray valid");
  property p_hld; !i_rd |=> $stable(o_rdata); endproperty
  a_hld: assert property (p_hld) else $error("data moved");
  property p_unm; i_rd && i_addr != 4'h0 |=> o_rdata == 32'h0000_0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  // Load, sample next cycle, read the cycle after: snapshot holds the load value
  property p_ld; i_param_load && i_param_valid ##1 i_input_sample_instant ##1 i_rd
    && i_addr == 4'h0 |=> o_rdata[24:0] == $past(i_param_load_value, 3); endproperty
  a_ld: assert property (p_ld) else $error("no load");
  property p_gt; i_param_load && i_param_input_fn == 2'h2 ##1 i_input_sample_instant
    ##1 i_rd && i_addr == 4'h0 |=> !o_rdata[25]; endproperty
  a_gt: assert property (p_gt) else $error("gate open");
  property p_cf; i_param_load && !i_param_valid ##1 i_input_sample_instant
    ##1 i_rd && i_addr == 4'h0 |=> o_rdata[29] && !o_rdata[25]; endproperty
  a_cf: assert property (p_cf) else $error("no fault");
  property p_sh; i_supply_short && i_input_sample_instant ##1 i_rd && i_addr == 4'h0
    |=> o_rdata[28]; endproperty
  a_sh: assert property (p_sh) else $error("no short");
endmodule
bind fast_mode_position_counter fmpc_props props_u (.i_clk, .i_rst, .i_param_load,
  .i_param_valid, .i_supply_short, .i_input_sample_instant, .i_rd, .o_word_valid,
  .i_param_load_value, .i_param_input_fn, .i_addr, .o_rdata);
`default_nettype wire

/* File: test/fb_master.sv */
`timescale 1ns/1ps
`default_nettype none
module fb_master (
  input  wire logic        i_clk,
  input  wire logic        i_word_valid,
  input  wire logic [31:0] i_rdata,
  output var logic         o_sample = 0,
  output var logic         o_rd = 0
);
  // Sample instant, then one whole-word read; gap models a slow master
  task automatic fetch(input int gap, output logic [31:0] w, output logic v);
    o_sample = 1;
    @(negedge i_clk) o_sample = 0;
    repeat (gap) @(negedge i_clk);
    o_rd = 1;
    @(negedge i_clk) o_rd = 0;
    {v, w} = {i_word_valid, i_rdata};
  endtask
endmodule
`default_nettype wire

/* File: test/fast_mode_position_counter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fast_mode_position_counter_test;
  logic        clk = 0, rst = 1, ld = 0, ok = 0, iso = 0, pls = 0, dn = 0, aux = 0, sc = 0;
  logic        hb = 0, inv = 0, smp, rd, wv, v;
  logic [24:0] lv = 0;
  logic [1:0]  fn = 0;
  logic [3:0]  adr = 0;
  logic [31:0] rdat, w;
  int          n_fail = 0, checks_done = 0;
  initial forever #2.5 clk = ~clk;
  fast_mode_position_counter dut_u (.i_clk(clk), .i_rst(rst), .i_param_load(ld),
    .i_param_load_value(lv), .i_param_input_fn(fn), .i_param_invert(inv), .i_param_valid(ok),
    .i_param_isochronous(iso), .i_count_pulse(pls), .i_count_down(dn), .i_aux_input(aux),
    .i_supply_short(sc), .i_input_sample_instant(smp), .i_rd(rd), .i_addr(adr),
    .o_rdata(rdat), .o_word_valid(wv));
  fb_master mst_u (.i_clk(clk), .i_word_valid(wv), .i_rdata(rdat), .o_sample(smp), .o_rd(rd));
  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Heartbeat flips on every sample; unmapped reads are slow and expect zero
  task automatic get(input logic [5:0] s, input logic [24:0] c);
    hb = ~hb;
    mst_u.fetch(adr, w, v);
    checks_done++;
    if (w !== (adr ? 32'h0000_0000 : {hb, s, c}) || v !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, w, {hb, s, c});
    end
  endtask
  task automatic cfg(input logic [1:0] f, input logic [24:0] x, input logic k);
    {ld, fn, lv, ok} = {1'b1, f, x, k};
    @(negedge clk) ld = 0;
  endtask
  task automatic step(input logic d);
    {pls, dn} = {1'b1, d};
    @(negedge clk) pls = 0;
  endtask
  // Two cycles let the edge detector see the new level
  task automatic din(input logic a);
    aux = a;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_param;
    get(6'h00, 25'h0);
    cfg(2'h1, 25'h0, 0);
    get(6'h10, 25'h0);
    // Inverted gate level without gate function is a fault too
    inv = 1;
    cfg(2'h1, 25'h0, 1);
    get(6'h10, 25'h0);
    inv = 0;
    cfg(2'h0, 25'h0, 1);
    get(6'h01, 25'h0);
  endtask
  task automatic t_wrap;
    iso = 1;
    cfg(2'h1, 25'h1FF_FFFF, 1);
    step(0);
    get(6'h21, 25'h0);
    step(1);
    get(6'h23, 25'h1FF_FFFF);
    iso = 0;
  endtask
  task automatic t_gate;
    cfg(2'h2, 25'h5, 1);
    get(6'h02, 25'h5);
    step(1);
    get(6'h02, 25'h5);
    din(1);
    step(1);
    get(6'h07, 25'h4);
    din(0);
    step(1);
    get(6'h02, 25'h4);
    din(1);
    step(1);
    get(6'h07, 25'h3);
  endtask
  task automatic t_sync;
    din(0);
    cfg(2'h3, 25'h10, 1);
    step(1);
    get(6'h03, 25'hF);
    din(1);
    get(6'h07, 25'h10);
    sc = 1;
    get(6'h0F, 25'h10);
    sc = 0;
    adr = 1;
    get(6'h00, 25'h0);
    adr = 0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_param;
    $display("param end");
    t_wrap;
    $display("wrap end");
    t_gate;
    $display("gate end");
    t_sync;
    $display("sync end");
    conclude;
  end
  // Watchdog against a hang
  initial begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
